//--- pkg/csi_rx_consts.vh
// Purpose: shared constants for the camera serial receiver front end
// Assumes: included by bare name from core files
// Notes: timing counts derive from the 50 MHz core clock
`ifndef CSI_RX_CONSTS_VH
`define CSI_RX_CONSTS_VH
`define MAX_LANES 4
`define MAX_STREAMS 4
`define SMALL_LANES 2
`define OUT_WIDTH 16
`define CORE_MAX_MHZ 200
`define TEST_RANGE_SEL 8'h44
`define RANGE_RESET 8'h00
`define SOT_ERR_LSB 0
`define FMT_YUV422 2'h0
`define FMT_RGB888 2'h1
`define FMT_GENERIC 2'h2
`define LANE_SYNC_BYTE 8'hb8
`define CLK_TIMEOUT 8'h10
`endif

//--- core/pair_buffer.v
// Purpose: two-entry valid/ready buffer in the output data path
// Assumes: single clock, synchronous active-high reset
// Notes: full throughput, ready depends only on fill level
`timescale 1ns/1ps
`default_nettype none
module pair_buffer #(
  parameter WIDTH = 16
) (
  input wire mclk,
  input wire rst,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] slot [0:1]; // storage entries
  reg wr_ptr; // next slot to fill
  reg rd_ptr; // next slot to drain
  reg [1:0] count; // entries held
  wire push;
  wire pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count != 2'h2); // honest full
  assign out_valid = (count != 2'h0); // honest empty
  assign out_data = slot[rd_ptr];
  // pointer and fill level update
  always @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      if (push) begin
        slot[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'h1;
      else if (pop && !push)
        count <= count - 2'h1;
    end
  end
endmodule // pair_buffer
`default_nettype wire

//--- core/csi_rx_front.v
// Purpose: camera serial receiver front end, lane merge to 16-bit bus
// Assumes: lane clock and lanes are sampled at mclk; one bit per lane
//   per lane-clock edge (both edges); sensor keeps its own ordering
// Notes: a behavioural model of the receive path at reduced rates
//
// Notes on behaviour
// R1 - up to four lanes, four streams; smaller: two; out_stream tags only streams 0 and 1
// R2 - core clock at most 200 MHz
// R3 - output data bus sixteen bits wide
// R4 - format sets output cycles per pixel
// R5 - lane rate bounds per active lane count
// R6 - several streams share summed core throughput
// R7 - core clock dedicated or shared with imaging
// R8 - sensor lanes in stop state before bring-up
// R9 - host order: lanes, power, phy, controller
// R10 - two id match and two mask settings; only error_match_ids_high is used, masks unused
// R11 - per-lane stop condition is readable
// R12 - sensor clock only after lanes stopped
// R13 - clock-lane activity is readable
// R14 - range code at or above lane clock
// R15 - range value is twice the lane clock
// R16 - range code from 29-band lookup
// R17 - start-of-transmission error per lane, bits 0-3
// R18 - reference clock 27 MHz assumed
// R19 - range loaded via test port, number 0x44
// R20 - range held until next test write
`timescale 1ns/1ps
`include "csi_rx_consts.vh"
`default_nettype none
module csi_rx_front #(
  parameter LANES = `MAX_LANES, // [R1] 2 for the smaller variant
  parameter STREAMS = `MAX_STREAMS
) (
  input wire mclk, // core clock, never above 200 MHz [R2] [R7]
  input wire rst,
  input wire lane_clk, // sensor clock lane, asynchronous
  input wire [3:0] lane_data, // data lanes, asynchronous
  input wire [3:0] lane_lp11, // per-lane stop (LP-11) level
  input wire [2:0] active_lanes, // 1..LANES
  input wire phy_power_on,
  input wire phy_reset_release,
  input wire controller_reset_release,
  input wire [1:0] pixel_format,
  input wire [7:0] error_match_ids_low, // [R10]
  input wire [7:0] error_match_ids_high,
  input wire [7:0] irq_mask_first,
  input wire [7:0] irq_mask_second,
  input wire test_clear, // test port clear
  input wire test_strobe, // test port clock
  input wire test_enable, // selects test number write
  input wire [7:0] phy_test_data_port, // test data byte
  input wire [7:0] lane_rate_code, // code needed by current lane rate
  output reg [7:0] range_code,
  output reg [3:0] lane_stop_condition,
  output reg clock_active,
  output reg [7:0] protocol_error_flags,
  output reg [15:0] out_data,
  output reg out_valid,
  input wire out_ready,
  output reg [1:0] out_stream,
  output reg [1:0] pix_phase
);
  // two-stage synchronisers for pins
  reg [5:0] sync_a;
  reg [5:0] sync_b;
  reg [3:0] stop_a;
  reg [3:0] stop_b;
  reg clk_prev; // last synced lane clock, for edge find
  reg [7:0] test_sel; // selected test number
  reg strobe_prev;
  reg [15:0] shift; // gathered lane bits
  reg [4:0] bitcnt; // bits gathered
  reg [7:0] idle_cnt; // edges absent counter
  reg in_frame; // after sync seen
  reg [1:0] fmt_cnt; // pacing for rgb888
  reg [15:0] word_q;
  reg word_v;
  wire lclk_s;
  wire [3:0] ldat_s;
  wire lclk_edge;
  wire buf_ready;
  wire [15:0] buf_data;
  wire buf_valid;
  wire running;
  wire strobe_rise;
  wire [3:0] lane_mask;
  wire [4:0] step;
  wire range_low;
  wire pop_now; // output stage takes a word from the buffer
  assign lclk_s = sync_b[4];
  assign ldat_s = sync_b[3:0];
  assign lclk_edge = lclk_s ^ clk_prev; // both edges carry data [R15]
  assign strobe_rise = sync_b[5] & ~strobe_prev;
  assign running = phy_power_on & phy_reset_release &
    controller_reset_release; // all three releases needed [R9]
  assign lane_mask = lanes_mask(active_lanes);
  assign step = {2'b00, active_lanes};
  assign range_low = range_code < lane_rate_code; // [R14] [R17]

  // mask of lanes in use, clipped to the variant width
  function [3:0] lanes_mask;
    input [2:0] n;
    begin
      case (n)
        3'h1: lanes_mask = 4'h1;
        3'h2: lanes_mask = 4'h3;
        3'h3: lanes_mask = (LANES > 2) ? 4'h7 : 4'h3;
        default: lanes_mask = (LANES > 2) ? 4'hf : 4'h3; // [R1]
      endcase
    end
  endfunction

  // pin synchronisers; first stage read only by second
  always @(posedge mclk) begin
    if (rst) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
      stop_a <= 4'h0;
      stop_b <= 4'h0;
    end else begin
      sync_a <= {test_strobe, lane_clk, lane_data};
      sync_b <= sync_a;
      stop_a <= lane_lp11;
      stop_b <= stop_a;
    end
  end

  // test port: range code latched on the strobe, held otherwise
  always @(posedge mclk) begin
    if (rst) begin
      range_code <= `RANGE_RESET;
      test_sel <= 8'h00;
      strobe_prev <= 1'b0;
    end else begin
      strobe_prev <= sync_b[5];
      if (test_clear)
        test_sel <= 8'h00;
      else if (strobe_rise && test_enable)
        test_sel <= phy_test_data_port; // test number write [R19]
      else if (strobe_rise && test_sel == `TEST_RANGE_SEL)
        range_code <= phy_test_data_port; // [R16] [R18] [R20]
    end
  end

  // lane state reporting; powered-down phy reports nothing
  always @(posedge mclk) begin
    if (rst) begin
      lane_stop_condition <= 4'h0;
      clock_active <= 1'b0;
      idle_cnt <= 8'h00;
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= lclk_s;
      lane_stop_condition <= (phy_power_on && phy_reset_release) ?
        (stop_b & lane_mask) : 4'h0; // [R11] [R8]
      if (lclk_edge)
        idle_cnt <= 8'h00;
      else if (idle_cnt != `CLK_TIMEOUT)
        idle_cnt <= idle_cnt + 8'h01;
      // clock seen while running, and edges not stale [R13] [R12]
      clock_active <= running && (idle_cnt != `CLK_TIMEOUT);
    end
  end

  // lane striping merge: gather lane bits into 16-bit words
  always @(posedge mclk) begin
    if (rst) begin
      shift <= 16'h0000;
      bitcnt <= 5'h00;
      in_frame <= 1'b0;
      word_q <= 16'h0000;
      word_v <= 1'b0;
      protocol_error_flags <= 8'h00;
    end else begin
      // clear first, so that a flag set in the same cycle survives
      if (test_clear)
        protocol_error_flags <= 8'h00;
      if (word_v && buf_ready)
        word_v <= 1'b0;
      // the first edge after a pause still carries a bit: keep it
      if (!running || (idle_cnt == `CLK_TIMEOUT && !lclk_edge)) begin
        in_frame <= 1'b0; // frame ends with the lane clock
        bitcnt <= 5'h00;
      end else if (lclk_edge && !word_v) begin
        // stall the merge while the word waits: no word lost
        if (!in_frame) begin
          shift <= {shift[11:0], ldat_s & lane_mask};
          if ({shift[3:0], ldat_s[3:0] & lane_mask} == 8'hb8 ||
              shift[7:0] == `LANE_SYNC_BYTE) begin
            in_frame <= 1'b1;
            bitcnt <= 5'h00;
            // range below lane rate: flag every active lane [R17]
            if (range_low)
              protocol_error_flags[`SOT_ERR_LSB+3:`SOT_ERR_LSB] <=
                (test_clear ? 4'h0 : protocol_error_flags[3:0]) |
                lane_mask;
          end
        end else begin
          shift <= merge(shift, ldat_s, active_lanes);
          if (bitcnt + step >= 5'h10) begin
            word_q <= merge(shift, ldat_s, active_lanes); // [R3]
            word_v <= 1'b1;
            bitcnt <= 5'h00;
          end else begin
            bitcnt <= bitcnt + step; // [R5] more lanes, fewer edges
          end
        end
      end
    end
  end

  // shift in one bit from each active lane, lane 0 first
  function [15:0] merge;
    input [15:0] s;
    input [3:0] d;
    input [2:0] n;
    begin
      case (n)
        3'h1: merge = {s[14:0], d[0]};
        3'h2: merge = {s[13:0], d[0], d[1]};
        3'h3: merge = {s[12:0], d[0], d[1], d[2]};
        default: merge = {s[11:0], d[0], d[1], d[2], d[3]};
      endcase
    end
  endfunction

  pair_buffer #(.WIDTH(`OUT_WIDTH)) out_buf (
    .mclk(mclk),
    .rst(rst),
    .in_data(word_q),
    .in_valid(word_v),
    .in_ready(buf_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(pop_now)
  );

  // output stage: rgb888 pauses every third cycle (1.5 per pixel) [R4]
  assign pop_now = buf_valid && (!out_valid || out_ready) &&
    !(pixel_format == `FMT_RGB888 && fmt_cnt == 2'h2);

  // registered output; stream tag from the matched id [R6] [R10]
  always @(posedge mclk) begin
    if (rst) begin
      out_data <= 16'h0000;
      out_valid <= 1'b0;
      out_stream <= 2'h0;
      pix_phase <= 2'h0;
      fmt_cnt <= 2'h0;
    end else begin
      if (pixel_format == `FMT_RGB888 && (!out_valid || out_ready))
        fmt_cnt <= (fmt_cnt == 2'h2) ? 2'h0 : fmt_cnt + 2'h1;
      if (pop_now) begin
        out_data <= buf_data;
        out_valid <= 1'b1;
        out_stream <= (buf_data[15:8] == error_match_ids_high) ?
          2'h1 : 2'h0;
        pix_phase <= (pixel_format == `FMT_GENERIC) ? 2'h2 : 2'h1;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule // csi_rx_front
`default_nettype wire

//--- tb/csi_rx_front_sva.sv
// Purpose: port checker for the receiver front end
// Assumes: one mclk domain, rst synchronous active high
// Notes: lane clock is sampled here by one flop, ahead of the core's two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
module csi_rx_front_sva (
  input wire mclk,
  input wire rst,
  input wire lane_clk,
  input wire [3:0] lane_lp11,
  input wire phy_power_on,
  input wire phy_reset_release,
  input wire controller_reset_release,
  input wire test_clear,
  input wire test_strobe,
  input wire [7:0] lane_rate_code,
  input wire [7:0] range_code,
  input wire [3:0] lane_stop_condition,
  input wire clock_active,
  input wire [7:0] protocol_error_flags,
  input wire [15:0] out_data,
  input wire out_valid,
  input wire out_ready,
  input wire [1:0] out_stream
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic [5:0] idle; // cycles since lane clock moved, saturating
  logic lc_q; // last sampled lane clock
  logic [3:0] clr_seen; // test_clear in the last four cycles
  wire up = phy_power_on & phy_reset_release & controller_reset_release;
  // helper state; idle saturates so a long pause never wraps
  always @(posedge mclk) begin
    lc_q <= lane_clk;
    clr_seen <= {clr_seen[2:0], test_clear};
    if (rst || lane_clk != lc_q) begin
      idle <= 6'h00;
    end else if (idle != 6'h3f) begin
      idle <= idle + 6'h01;
    end
  end
  // lanes held at one level long enough to cross the synchroniser
  sequence lp_settled;
    (up && $stable(lane_lp11)) [*4];
  endsequence
  a_reset_quiet: assert property ($past(rst) |->
    !out_valid && protocol_error_flags == 8'h00 && range_code == 8'h00)
    else $error("outputs not clear after reset");
  a_range_held: assert property (!$past(rst) &&
    !$stable(range_code) |-> $past(test_strobe, 2) || $past(test_strobe, 3))
    else $error("range code moved without a strobe");
  a_flags_sticky: assert property (!$past(rst) &&
    |($past(protocol_error_flags[3:0]) & ~protocol_error_flags[3:0])
    |-> |clr_seen) else $error("lane error flag fell without clear");
  a_flags_cause: assert property (!$past(rst) &&
    |(protocol_error_flags[3:0] & ~$past(protocol_error_flags[3:0]))
    |-> $past(range_code) < $past(lane_rate_code))
    else $error("lane error flag set with range high enough");
  a_valid_holds: assert property (
    out_valid && !out_ready |=> out_valid)
    else $error("valid dropped before ready");
  a_data_holds: assert property (
    out_valid && !out_ready |=> $stable(out_data) && $stable(out_stream))
    else $error("word changed while waiting");
  a_clock_idle: assert property (
    clock_active |-> idle < 6'h18) else $error("clock active while idle");
  a_clock_seen: assert property (
    up && lane_clk != lc_q |-> ##[1:6] clock_active)
    else $error("lane clock edge not reported");
  a_stop_level: assert property (
    lp_settled |-> lane_stop_condition == lane_lp11)
    else $error("stop condition differs from lanes");
endmodule // csi_rx_front_sva
`default_nettype wire

//--- tb/sensor_model.sv
// Purpose: sensor side: clock lane and four data lanes
// Assumes: four active lanes, lane clock period 160 ns inside frames
// Notes: clock stands still between frames; idle data is inverted
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  input wire logic go,
  input wire logic [15:0] w0,
  input wire logic [15:0] w1,
  output logic lane_clk,
  output logic [3:0] lane_data,
  output logic [3:0] lane_lp11
);
  logic [39:0] bits; // sync byte then two words, top nibble first
  integer k;
  // the receiver puts lane 0 at the top of each nibble of a word
  function automatic logic [15:0] flip(input logic [15:0] w);
    integer i;
    for (i = 0; i < 16; i = i + 1)
      flip[i] = w[i ^ 3];
  endfunction
  initial begin
    lane_clk = 1'b0;
    lane_data = 4'h0;
    lane_lp11 = 4'hf; // lanes rest in stop state before bring-up
  end
  // one burst per rising go; data moves midway between clock edges
  always @(posedge go) begin
    bits = {8'hb8, flip(w0), flip(w1)};
    lane_lp11 = 4'h0;
    #80;
    for (k = 0; k < 10; k = k + 1) begin
      lane_data = bits[36-4*k +: 4]; // sync goes raw, words flipped
      #40 lane_clk = ~lane_clk; // each edge carries a bit
      #40;
    end
    lane_lp11 = 4'hf; // back to stop state after the burst
    lane_data = ~lane_data; // released lines must not keep old bits
  end
endmodule // sensor_model
`default_nettype wire

//--- tb/test_csi_rx_front.sv
// Purpose: bench for the receiver front end: setup, bursts, errors
// Assumes: 50 MHz mclk, four lanes, sensor model on the lane side
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`default_nettype none
module test_csi_rx_front;
  logic mclk, rst, test_clear, test_strobe, test_enable, out_ready, go;
  logic phy_power_on, phy_reset_release, controller_reset_release;
  logic lane_clk, clock_active, out_valid;
  logic [2:0] active_lanes;
  logic [3:0] lane_data, lane_lp11, lane_stop_condition;
  logic [7:0] phy_test_data_port, lane_rate_code, range_code;
  logic [7:0] protocol_error_flags;
  logic [15:0] out_data, w0, w1;
  logic [1:0] out_stream, pix_phase;
  integer fails = 0, total_checks = 0, n;
  csi_rx_front dut (.*, .pixel_format(2'h0), .error_match_ids_low(8'h00),
    .error_match_ids_high(8'h40), .irq_mask_first(8'h00),
    .irq_mask_second(8'h00));
  sensor_model sensor (.*);
  task cyc(input integer c);
    repeat (c) @(negedge mclk);
  endtask
  task chk(input string what, input logic [15:0] e, input logic [15:0] g);
    total_checks = total_checks + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  // test-port write; strobe is long so the synchroniser sees it
  task tst(input logic en, input logic [7:0] b);
    test_enable = en;
    phy_test_data_port = b;
    cyc(2);
    test_strobe = 1'b1;
    cyc(6);
    test_strobe = 1'b0;
    cyc(6);
  endtask
  // clear, select the range test number, then write the range byte
  task set_range(input logic [7:0] b);
    test_clear = 1'b1;
    cyc(2);
    test_clear = 1'b0;
    tst(1'b1, 8'h44);
    tst(1'b0, b);
  endtask
  // one burst: clock seen inside it, gone after the idle timeout
  task frame;
    go = 1'b1; // host saw all lanes stopped first
    cyc(20);
    chk("clk_on", 16'h0001, {15'h0000, clock_active});
    cyc(100);
    chk("clk_off", 16'h0000, {15'h0000, clock_active});
    go = 1'b0;
  endtask
  // take one word; ready is raised only while valid is shown
  task take(input logic [15:0] e);
    n = 0;
    cyc(1);
    while (out_valid !== 1'b1 && n < 50) begin
      n = n + 1;
      cyc(1);
    end
    chk("word", e, out_data);
    chk("stream", 16'h0000, {14'h0000, out_stream});
    chk("phase", 16'h0001, {14'h0000, pix_phase});
    out_ready = 1'b1;
    cyc(1);
    out_ready = 1'b0;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // the whole run needs about 370 cycles; cut off far beyond that
  initial begin
    #100000;
    fails = fails + 1;
    end_sim;
  end
  initial begin
    {rst, go, w0, w1} = {1'b1, 1'b0, 16'h1234, 16'hbeef};
    {test_clear, test_strobe, test_enable, out_ready} = 4'h0;
    {phy_power_on, phy_reset_release, controller_reset_release} = 3'h0;
    {active_lanes, phy_test_data_port, lane_rate_code} = {3'h4, 16'h002e};
    cyc(5);
    rst = 1'b0;
    set_range(8'h2e); // 550-600 band, 27 MHz
    chk("range", 16'h002e, {8'h00, range_code});
    test_clear = 1'b1;
    tst(1'b0, 8'h74); // strobe while clear is held is refused
    test_clear = 1'b0;
    chk("range", 16'h002e, {8'h00, range_code});
    phy_power_on = 1'b1; // lanes first, then power, phy, controller
    cyc(2);
    phy_reset_release = 1'b1;
    cyc(2);
    controller_reset_release = 1'b1;
    cyc(8);
    chk("range", 16'h002e, {8'h00, range_code});
    chk("stop", 16'h000f, {12'h000, lane_stop_condition});
    frame;
    chk("flags", 16'h0000, {12'h000, protocol_error_flags[3:0]});
    take(16'h1234);
    take(16'hbeef);
    cyc(2);
    chk("empty", 16'h0000, {15'h0000, out_valid});
    set_range(8'h0e); // below the code the lane rate needs
    frame;
    chk("flags", 16'h000f, {12'h000, protocol_error_flags[3:0]});
    set_range(8'h2e); // clear also wipes the sticky flags
    chk("flags", 16'h0000, {12'h000, protocol_error_flags[3:0]});
    end_sim;
  end
endmodule // test_csi_rx_front
bind csi_rx_front csi_rx_front_sva checker_i (.*);
`default_nettype wire
